/* ucr_defs.vh */
`ifndef UCR_DEFS_VH
`define UCR_DEFS_VH
// Register offsets
`define UCR_CTRL_ADDR 8'h30
`define UCR_DIV_ADDR 8'h24
`define UCR_STAT_ADDR 8'h40
// Control register fields
`define UCR_EN_BIT 0
`define UCR_OVS_BIT 3
`define UCR_TXE_BIT 8
`define UCR_RXE_BIT 9
`define UCR_RTS_BIT 11
`define UCR_RFC_BIT 14
`define UCR_TFC_BIT 15
`define UCR_SBL_LSB 16
`define UCR_SBL_MSB 19
`define UCR_CTRL_MASK 32'h000FCB09
`define UCR_CTRL_RESET 32'h00040300
`define UCR_DIV_RESET 16'h0001
// Baud ticks per bit
`define UCR_OVS16 5'h10
`define UCR_OVS8 5'h08
`endif

/* ucr_serial_dev.sv */
`timescale 1ns/1ps
module ucr_serial_dev (
  input wire clk_i,
  input wire txd_i,
  output reg rxd_o,
  output reg cts_n_o
);
  // Line idles high, as with a pull-up
  initial begin
    rxd_o = 1'b1;
    cts_n_o = 1'b0;
  end
  // One frame out, start, LSB first, stop
  task send(input [7:0] d, input integer bl);
    integer i;
    begin
      for (i = 0; i < 10; i = i + 1) begin
        rxd_o <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : d[i-1];
        repeat (bl) @(posedge clk_i);
      end
    end
  endtask
  // Capture one frame at mid-bit
  task get(output [7:0] d, input integer bl);
    integer i;
    begin
      @(negedge txd_i);
      repeat (bl / 2) @(posedge clk_i);
      for (i = 0; i < 8; i = i + 1) begin
        repeat (bl) @(posedge clk_i);
        d[i] = txd_i;
      end
    end
  endtask
  task set_cts(input c);
    begin
      @(posedge clk_i);
      cts_n_o <= c;
    end
  endtask
endmodule

/* ucr_top.v */
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`include "ucr_defs.vh"
module ucr_top #(
  parameter DIV_W = 16
) (
  input wire clk_i,
  input wire resetn_i,
  input wire [7:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  input wire [7:0] tx_data_i,
  input wire tx_valid_i,
  output reg tx_ready_o,
  output reg [7:0] rx_data_o,
  output reg rx_valid_o,
  input wire rx_ready_i,
  output reg txd_o,
  input wire rxd_i,
  output reg rts_n_o,
  input wire cts_n_i
);
  localparam S_IDLE = 2'h0;
  localparam S_START = 2'h1;
  localparam S_DATA = 2'h2;
  localparam S_STOP = 2'h3;

  reg [31:0] ctrl_r;
  reg [DIV_W-1:0] div_r;
  wire en = ctrl_r[`UCR_EN_BIT];
  wire ovs8 = ctrl_r[`UCR_OVS_BIT];
  wire [3:0] sbl = ctrl_r[`UCR_SBL_MSB:`UCR_SBL_LSB];

  // Register writes
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_r <= `UCR_CTRL_RESET;
      div_r <= `UCR_DIV_RESET;
    end else if (wr_i) begin
      if (addr_i == `UCR_CTRL_ADDR)
        ctrl_r <= wdata_i & `UCR_CTRL_MASK;
      // Divisor register holds the integer divisor only
      if (addr_i == `UCR_DIV_ADDR) begin
        // A zero divisor would stretch the tick to 65536 clocks; it is taken as one
        if (wdata_i[DIV_W-1:0] == {DIV_W{1'b0}})
          div_r <= `UCR_DIV_RESET;
        else
          div_r <= wdata_i[DIV_W-1:0];
      end
    end
  end

  // Baud tick: one enable pulse per oversample clock group
  // A divisor lowered mid-count is caught by the >= compare, not a wrap
  reg [DIV_W-1:0] bdiv_r;
  reg tick_r;
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bdiv_r <= {DIV_W{1'b0}};
      tick_r <= 1'b0;
    end else if (bdiv_r >= div_r - 1'b1) begin
      bdiv_r <= {DIV_W{1'b0}};
      tick_r <= 1'b1;
    end else begin
      bdiv_r <= bdiv_r + 1'b1;
      tick_r <= 1'b0;
    end
  end

  // ticks per bit; bit period = divisor x 16 or 8
  function [4:0] bit_len;
    input sel;
    begin
      bit_len = sel ? `UCR_OVS8 : `UCR_OVS16;
    end
  endfunction
  wire [4:0] nbit = bit_len(ovs8);

  // Occupancy step of a two-entry buffer; push and pop may share a cycle
  function [1:0] cnt_step;
    input [1:0] cnt;
    input up;
    input dn;
    begin
      cnt_step = cnt + {1'b0, up} - {1'b0, dn};
    end
  endfunction

  // Transmit two-entry buffer; stall of the line loses no word
  reg [7:0] tb_r [0:1];
  reg [1:0] tcnt_r;
  // Write and read pointers toggle between the two slots
  reg twp_r, trp_r;
  wire tpush = tx_valid_i && tx_ready_o;
  reg tpop;

  // Transmitter
  reg [1:0] ts_r;
  reg [4:0] tt_r;
  reg [2:0] tb_idx_r;
  // Shifter loaded at the start edge so the buffer slot frees early
  reg [7:0] tsh_r;
  // clear-to-send gates only the start of a character
  wire cts_ok = !ctrl_r[`UCR_TFC_BIT] || !cts_n_i;
  always @* begin
    // start only when enabled; ongoing character runs on
    // start waits for a tick so every bit is whole ticks long
    tpop = (ts_r == S_IDLE) && tick_r && en && ctrl_r[`UCR_TXE_BIT] && cts_ok &&
      (tcnt_r != 2'h0);
  end
  // Buffer occupancy after this cycle's push and pop
  wire [1:0] tcnt_nxt = cnt_step(tcnt_r, tpush, tpop);

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tcnt_r <= 2'h0;
      twp_r <= 1'b0;
      trp_r <= 1'b0;
      tx_ready_o <= 1'b0;
      tb_r[0] <= 8'h00;
      tb_r[1] <= 8'h00;
    end else begin
      if (tpush) begin
        tb_r[twp_r] <= tx_data_i;
        twp_r <= ~twp_r;
      end
      if (tpop)
        trp_r <= ~trp_r;
      tcnt_r <= tcnt_nxt;
      // Ready registered: conservative while one word arrives
      // Going low a cycle early is safe; going low late would lose a word
      tx_ready_o <= (tcnt_nxt == 2'h0) || ((tcnt_nxt == 2'h1) && !tpush);
    end
  end

  // Transmit state machine; txd_o registered so the pin never glitches
  // Limitation: a rate change mid-character bends that character
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ts_r <= S_IDLE;
      tt_r <= 5'h00;
      tb_idx_r <= 3'h0;
      tsh_r <= 8'h00;
      txd_o <= 1'b1;
    end else begin
      case (ts_r)
        S_IDLE: begin
          txd_o <= 1'b1;
          tt_r <= 5'h00;
          if (tpop) begin
            tsh_r <= tb_r[trp_r];
            ts_r <= S_START;
            txd_o <= 1'b0;
          end
        end
        S_START, S_DATA, S_STOP: begin
          if (tick_r) begin
            if (tt_r == nbit - 1'b1) begin
              tt_r <= 5'h00;
              if (ts_r == S_START) begin
                ts_r <= S_DATA;
                tb_idx_r <= 3'h0;
                txd_o <= tsh_r[0];
              end else if (ts_r == S_DATA) begin
                if (tb_idx_r == 3'h7) begin
                  ts_r <= S_STOP;
                  txd_o <= 1'b1;
                end else begin
                  tb_idx_r <= tb_idx_r + 1'b1;
                  txd_o <= tsh_r[tb_idx_r + 1'b1];
                end
              end else begin
                ts_r <= S_IDLE;
              end
            end else begin
              tt_r <= tt_r + 1'b1;
            end
          end
        end
        default: ts_r <= S_IDLE;
      endcase
    end
  end

  // Receive two-entry buffer
  reg [7:0] rb_r [0:1];
  reg [1:0] rcnt_r;
  reg rwp_r, rrp_r;
  reg rpush_r;
  reg [7:0] rsh_r;
  wire rpop = rx_valid_o && rx_ready_i;
  // Receive occupancy after this cycle's push and pop
  wire [1:0] rcnt_nxt = cnt_step(rcnt_r, rpush_r, rpop);

  // Receiver
  reg [1:0] rs_r;
  reg [4:0] rt_r;
  reg [2:0] ri_r;
  // short start length only at top speed with 8-clock bits
  wire fast = ovs8 && (div_r == `UCR_DIV_RESET);
  wire [4:0] half = fast ? {1'b0, sbl} : (nbit >> 1) - 1'b1;

  // Receive state machine; a high line at the start centre is a glitch
  // Limitation: rxd_i is used directly, so it must come from this clock
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rs_r <= S_IDLE;
      rt_r <= 5'h00;
      ri_r <= 3'h0;
      rsh_r <= 8'h00;
      rpush_r <= 1'b0;
    end else begin
      rpush_r <= 1'b0;
      case (rs_r)
        S_IDLE: begin
          rt_r <= 5'h00;
          if (en && ctrl_r[`UCR_RXE_BIT] && !rxd_i)
            rs_r <= S_START;
        end
        S_START: begin
          if (tick_r) begin
            if (rt_r >= half) begin
              rt_r <= 5'h00;
              ri_r <= 3'h0;
              rs_r <= rxd_i ? S_IDLE : S_DATA;
            end else begin
              rt_r <= rt_r + 1'b1;
            end
          end
        end
        S_DATA: begin
          if (tick_r) begin
            if (rt_r == nbit - 1'b1) begin
              rt_r <= 5'h00;
              rsh_r <= {rxd_i, rsh_r[7:1]};
              if (ri_r == 3'h7)
                rs_r <= S_STOP;
              ri_r <= ri_r + 1'b1;
            end else begin
              rt_r <= rt_r + 1'b1;
            end
          end
        end
        S_STOP: begin
          // character completes even if enable dropped
          if (tick_r) begin
            if (rt_r == nbit - 1'b1) begin
              rs_r <= S_IDLE;
              rpush_r <= rxd_i && (rcnt_r != 2'h2);
            end else begin
              rt_r <= rt_r + 1'b1;
            end
          end
        end
        default: rs_r <= S_IDLE;
      endcase
    end
  end

  // Receive buffer; a full buffer drops the character, never overwrites
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rcnt_r <= 2'h0;
      rwp_r <= 1'b0;
      rrp_r <= 1'b0;
      rb_r[0] <= 8'h00;
      rb_r[1] <= 8'h00;
    end else begin
      if (rpush_r) begin
        rb_r[rwp_r] <= rsh_r;
        rwp_r <= ~rwp_r;
      end
      if (rpop)
        rrp_r <= ~rrp_r;
      rcnt_r <= rcnt_nxt;
    end
  end

  // Receive output stage driven from the buffer head
  // Refills on the pop edge so a waiting word follows with no bubble
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_valid_o <= 1'b0;
      rx_data_o <= 8'h00;
    end else begin
      if (!rx_valid_o || rpop) begin
        rx_valid_o <= (rcnt_r - {1'b0, rpop}) != 2'h0;
        rx_data_o <= rpop ? rb_r[~rrp_r] : rb_r[rrp_r];
      end
    end
  end

  // Request-to-send output, active low
  // Trade-off: releasing at one held word wastes a slot but covers a
  // character already on the wire when the far side sees the release
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rts_n_o <= 1'b1;
    end else if (ctrl_r[`UCR_RFC_BIT]) begin
      // request only with room; one slot kept for a character in flight
      rts_n_o <= (rcnt_r != 2'h0);
    end else begin
      rts_n_o <= ~ctrl_r[`UCR_RTS_BIT];
    end
  end

  // Register reads, one cycle later
  // Cycles without a read return zero so stale data is never mistaken
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 32'h00000000;
    end else if (rd_i) begin
      case (addr_i)
        `UCR_CTRL_ADDR: rdata_o <= ctrl_r;
        `UCR_DIV_ADDR: rdata_o <= {{(32-DIV_W){1'b0}}, div_r};
        `UCR_STAT_ADDR: rdata_o <= {24'h000000, rcnt_r, tcnt_r, ts_r, rs_r};
        default: rdata_o <= 32'h00000000;
      endcase
    end else begin
      rdata_o <= 32'h00000000;
    end
  end
endmodule

/* ucr_top_props.sv */
`timescale 1ns/1ps
`include "ucr_defs.vh"
module ucr_top_props (
  input wire clk_i,
  input wire resetn_i,
  input wire [7:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [31:0] rdata_o,
  input wire [7:0] rx_data_o,
  input wire rx_valid_o,
  input wire rx_ready_i,
  input wire txd_o,
  input wire rts_n_o
);
  reg [31:0] ctl_r;
  reg [11:0] low_r;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // Shadow control word; low runs always lie inside a frame
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctl_r <= `UCR_CTRL_RESET;
      low_r <= 12'h000;
    end else begin
      if (wr_i && addr_i == `UCR_CTRL_ADDR) ctl_r <= wdata_i & `UCR_CTRL_MASK;
      low_r <= txd_o ? 12'h000 : low_r + 12'h001;
    end
  end
  AST_RD_IDLE: assert property (!$past(rd_i) |-> rdata_o == 32'h00000000)
    else $error("rdata not zero");
  AST_CTRL_RD: assert property ($past(rd_i) && $past(addr_i) == 8'h30
    |-> rdata_o == $past(ctl_r)) else $error("ctrl readback");
  AST_UNMAP: assert property ($past(rd_i) && $past(addr_i) == 8'h10
    |-> rdata_o == 32'h00000000) else $error("unmapped read");
  AST_RTS_SW: assert property ((!ctl_r[14] && $stable(ctl_r))[*3]
    |-> rts_n_o == !ctl_r[11]) else $error("rts level");
  AST_RTS_FC: assert property ((ctl_r[14] && rx_valid_o)[*2] |-> rts_n_o)
    else $error("rts with full buffer");
  AST_RX_HOLD: assert property (rx_valid_o && !rx_ready_i
    |=> rx_valid_o && $stable(rx_data_o)) else $error("rx word lost");
  AST_BIT8: assert property ($rose(txd_o) |-> low_r[2:0] == 3'h0)
    else $error("bit length");
  AST_BIT16: assert property ($rose(txd_o) && !ctl_r[3] |-> low_r[3:0] == 4'h0)
    else $error("bit length 16");
endmodule
bind ucr_top ucr_top_props i_ucr_top_props (.clk_i, .resetn_i, .addr_i, .wdata_i, .wr_i,
  .rd_i, .rdata_o, .rx_data_o, .rx_valid_o, .rx_ready_i, .txd_o, .rts_n_o);

/* ucr_top_tb.sv */
`timescale 1ns/1ps
`include "ucr_defs.vh"
`define CHK(n, e, g) begin cmp_count = cmp_count + 1; if ((g) !== (e)) begin \
  miscompares = miscompares + 1; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module ucr_top_tb;
  reg clk_i, resetn_i, wr_i, rd_i, tx_valid_i, rx_ready_i;
  reg [7:0] addr_i, tx_data_i, g;
  reg [31:0] wdata_i, v, seed;
  wire [31:0] rdata_o;
  wire [7:0] rx_data_o;
  wire tx_ready_o, rx_valid_o, txd_o, rxd_i, rts_n_o, cts_n_i;
  integer cmp_count, miscompares, m, bl;
  ucr_top i_ucr_top (.clk_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .tx_data_i,
    .tx_valid_i, .tx_ready_o, .rx_data_o, .rx_valid_o, .rx_ready_i, .txd_o, .rxd_i, .rts_n_o,
    .cts_n_i);
  ucr_serial_dev i_ucr_serial_dev (.clk_i, .txd_i(txd_o), .rxd_o(rxd_i), .cts_n_o(cts_n_i));
  // Bus cycles and stream handshakes
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(negedge clk_i);
      v = rdata_o;
    end
  endtask
  task push;
    begin
      v = $random(seed);
      @(posedge clk_i);
      tx_data_i <= v[7:0];
      tx_valid_i <= 1'b1;
      @(negedge clk_i);
      while (tx_ready_o !== 1'b1) @(negedge clk_i);
      @(posedge clk_i);
      tx_valid_i <= 1'b0;
    end
  endtask
  // Receiver stalls a cycle before taking the word
  task take;
    begin
      @(negedge clk_i);
      while (rx_valid_o !== 1'b1) @(negedge clk_i);
      g = rx_data_o;
      @(negedge clk_i);
      `CHK("rts full", 1'b1, rts_n_o)
      @(posedge clk_i);
      rx_ready_i <= 1'b1;
      @(posedge clk_i);
      rx_ready_i <= 1'b0;
    end
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
        $display("Testbench passed");
      end else begin
        $display("Testbench failed");
      end
      $finish;
    end
  endtask
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // Watchdog: run needs under 10000 cycles
  initial begin
    repeat (30000) @(posedge clk_i);
    miscompares = miscompares + 1;
    summarize;
  end
  initial begin
    {resetn_i, wr_i, rd_i, tx_valid_i, rx_ready_i, addr_i, tx_data_i, wdata_i} = 0;
    seed = 32'h46A732C6;
    cmp_count = 0;
    miscompares = 0;
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    // Reset values, reserved bits, unmapped place
    rd(8'h30);
    `CHK("ctrl reset", `UCR_CTRL_RESET, v)
    `CHK("rts reset", 1'b1, rts_n_o)
    wr(8'h30, 32'hFFFFFFFF);
    rd(8'h30);
    `CHK("ctrl mask", `UCR_CTRL_MASK, v)
    rd(8'h10);
    `CHK("unmapped", 32'h00000000, v)
    wr(8'h30, 32'h00000800);
    repeat (4) @(negedge clk_i);
    `CHK("rts forced", 1'b0, rts_n_o)
    $display("test regs done");
    // Word held while port is off; start length int(8/2)-1
    wr(8'h30, 32'h00000300);
    push;
    repeat (300) @(negedge clk_i);
    `CHK("txd off", 1'b1, txd_o)
    wr(8'h30, 32'h00034309);
    i_ucr_serial_dev.get(g, 8);
    `CHK("tx held", v[7:0], g)
    // Both rates and divisor 2, both directions
    for (m = 0; m < 3; m = m + 1) begin
      bl = (m == 1) ? 8 : (m == 2) ? 32 : 16;
      wr(8'h24, (m == 2) ? 32'h00000002 : 32'h00000001);
      wr(8'h30, (m == 1) ? 32'h00034309 : 32'h00044301);
      push;
      i_ucr_serial_dev.get(g, bl);
      `CHK("tx byte", v[7:0], g)
      v = $random(seed);
      i_ucr_serial_dev.send(v[7:0], bl);
      take;
      `CHK("rx byte", v[7:0], g)
    end
    $display("test modes done");
    // Remote withholds clear-to-send
    wr(8'h30, 32'h00048301);
    i_ucr_serial_dev.set_cts(1'b1);
    push;
    repeat (400) @(negedge clk_i);
    `CHK("txd paused", 1'b1, txd_o)
    i_ucr_serial_dev.set_cts(1'b0);
    i_ucr_serial_dev.get(g, 32);
    `CHK("tx after cts", v[7:0], g)
    // Disable in mid-frame still finishes the frame
    fork
      i_ucr_serial_dev.get(g, 32);
      begin
        push;
        repeat (100) @(posedge clk_i);
        wr(8'h30, 32'h00048300);
      end
    join
    `CHK("tx finished", v[7:0], g)
    $display("test flow done");
    summarize;
  end
endmodule
